// ---- rtl/araf_pkg.sv ----
// Purpose: Shared constants and carriers for the range and alarm flag register bank.
// Assumes: Program registers are addressed by a 7-bit register address.
// Notes:   Offsets, field positions and reset values live here only.
package araf_pkg;

  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned CH_W      = 3;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned SPAN_W    = 4;
  localparam int unsigned CONV_W    = 18;

  // Register offsets.
  localparam logic [ADDR_W-1:0] SPAN_FIRST_ADDR = 7'h05;
  localparam logic [ADDR_W-1:0] SPAN_LAST_ADDR  = 7'h0c;
  localparam logic [ADDR_W-1:0] OVERVIEW_ADDR   = 7'h10;
  localparam logic [ADDR_W-1:0] TRIP_LOW4_ADDR  = 7'h11;
  localparam logic [ADDR_W-1:0] ACT_LOW4_ADDR   = 7'h12;
  localparam logic [ADDR_W-1:0] TRIP_HIGH4_ADDR = 7'h13;
  localparam logic [ADDR_W-1:0] ACT_HIGH4_ADDR  = 7'h14;

  // Field layout and reset values.
  localparam int unsigned        SPAN_LSB       = 0;
  localparam logic [3:0]         SPAN_UPPER_RD  = 4'h0;
  localparam logic [SPAN_W-1:0]  SPAN_RESET     = 4'h0;
  localparam logic [DATA_W-1:0]  FLAG_RESET     = 8'h00;
  localparam logic [DATA_W-1:0]  ABSENT_RD      = 8'hff;
  localparam logic [DATA_W-1:0]  UNMAPPED_RD    = 8'h00;
  localparam logic [3:0]         ABSENT_NIBBLE  = 4'hf;

  // Span codes.
  localparam logic [SPAN_W-1:0] SPAN_BI_2P5   = 4'h0;
  localparam logic [SPAN_W-1:0] SPAN_BI_1P25  = 4'h1;
  localparam logic [SPAN_W-1:0] SPAN_BI_0P625 = 4'h2;
  localparam logic [SPAN_W-1:0] SPAN_UNI_2P5  = 4'h5;
  localparam logic [SPAN_W-1:0] SPAN_UNI_1P25 = 4'h6;

  // One register access from the serial frame decoder.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] wdata;
  } araf_reg_req_type;

  // One finished conversion.
  typedef struct packed {
    logic              valid;
    logic [CH_W-1:0]   ch;
    logic [CONV_W-1:0] data;
  } araf_conv_type;

endpackage

// ---- rtl/araf_span_mem.sv ----
// Purpose: Eight-entry store of the channel span select fields.
// Assumes: One writer; two independent read ports.
// Notes:   Both read ports return data from a register one cycle after the address.
module araf_span_mem
  import araf_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              we,
  input  wire logic [CH_W-1:0]   waddr,
  input  wire logic [SPAN_W-1:0] wdata,
  input  wire logic [CH_W-1:0]   raddr_a,
  output logic      [SPAN_W-1:0] q_a,
  input  wire logic [CH_W-1:0]   raddr_b,
  output logic      [SPAN_W-1:0] q_b
);

  logic [NUM_CH-1:0][SPAN_W-1:0] mem_ff;
  logic [SPAN_W-1:0]             q_a_ff;
  logic [SPAN_W-1:0]             q_b_ff;

  // Storage is cleared by reset so every channel starts in the widest bipolar span.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_ff <= {NUM_CH{SPAN_RESET}};
      q_a_ff <= SPAN_RESET;
      q_b_ff <= SPAN_RESET;
    end else begin
      if (we) begin
        mem_ff[waddr] <= wdata;
      end
      q_a_ff <= mem_ff[raddr_a];
      q_b_ff <= mem_ff[raddr_b];
    end
  end

  assign q_a = q_a_ff;
  assign q_b = q_b_ff;

endmodule

// ---- rtl/araf_top.sv ----
// Purpose: Range select and alarm flag program registers of a multichannel converter.
// Assumes: Register requests and conversion results arrive on clk_sys from on-chip logic.
// Notes:   The serial frame decoder owns shifting; this block sees whole bytes.
module araf_top
  import araf_pkg::*;
#(
  parameter bit EIGHT_CH = 1'b1
)(
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire araf_reg_req_type               reg_req,
  output logic                                reg_rvalid,
  output logic      [DATA_W-1:0]              serial_data_output,
  input  wire araf_conv_type                  conv,
  input  wire logic [NUM_CH-1:0][CONV_W-1:0]  thr_high,
  input  wire logic [NUM_CH-1:0][CONV_W-1:0]  thr_low,
  input  wire logic [CH_W-1:0]                span_query_ch,
  output logic      [SPAN_W-1:0]              channel_span_select,
  output logic                                span_code_legal,
  output logic                                alarm_out
);

  // Whether a channel exists in the built variant.
  function automatic logic ch_present(input logic [CH_W-1:0] ch);
    return EIGHT_CH || !ch[CH_W-1];
  endfunction

  // Packs four channels into one flag byte, low flag above high flag per pair.
  function automatic logic [DATA_W-1:0] pack_flags(input logic [3:0] lo, input logic [3:0] hi);
    return {lo[0], hi[0], lo[1], hi[1], lo[2], hi[2], lo[3], hi[3]};
  endfunction

  logic [NUM_CH-1:0] act_high_ff;
  logic [NUM_CH-1:0] act_low_ff;
  logic [NUM_CH-1:0] trip_high_ff;
  logic [NUM_CH-1:0] trip_low_ff;
  logic [NUM_CH-1:0] nxt_trip_high;
  logic [NUM_CH-1:0] nxt_trip_low;
  logic [NUM_CH-1:0] cond_high;
  logic [NUM_CH-1:0] cond_low;
  logic [NUM_CH-1:0] conv_hit;
  logic [NUM_CH-1:0] clr_mask;
  logic [NUM_CH-1:0] overview;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic              rvalid_ff;
  logic              span_rd_ff;
  logic              span_absent_rd_ff;
  logic              alarm_ff;
  logic [SPAN_W-1:0] span_host_q;
  logic [SPAN_W-1:0] span_query_q;

  // Span register address decode.
  wire              span_hit  = reg_req.addr >= SPAN_FIRST_ADDR &&
                                reg_req.addr <= SPAN_LAST_ADDR;
  wire [ADDR_W-1:0] span_off  = reg_req.addr - SPAN_FIRST_ADDR;
  wire [CH_W-1:0]   span_ch   = span_off[CH_W-1:0];
  wire              span_live = span_hit && ch_present(span_ch);
  wire              span_we   = reg_req.wr_en && span_live;
  wire              rd_trip_lo4 = reg_req.rd_en && reg_req.addr == TRIP_LOW4_ADDR;
  wire              rd_trip_hi4 = reg_req.rd_en && reg_req.addr == TRIP_HIGH4_ADDR && EIGHT_CH;

  // Only the span field is stored; the upper nibble has no storage and reads zero.
  araf_span_mem u_span_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (span_we),
    .waddr   (span_ch),
    .wdata   (reg_req.wdata[SPAN_LSB +: SPAN_W]),
    .raddr_a (span_ch),
    .q_a     (span_host_q),
    .raddr_b (span_query_ch),
    .q_b     (span_query_q)
  );

  // Threshold comparison per channel; flags of absent channels never set.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_cmp
      assign conv_hit[gi]  = conv.valid && conv.ch == CH_W'(gi) && ch_present(CH_W'(gi));
      assign cond_high[gi] = conv_hit[gi] && conv.data > thr_high[gi];
      assign cond_low[gi]  = conv_hit[gi] && conv.data < thr_low[gi];
    end
  endgenerate

  // A read of a tripped register clears the four channels that register holds.
  assign clr_mask      = {{4{rd_trip_hi4}}, {4{rd_trip_lo4}}};
  assign nxt_trip_high = (trip_high_ff & ~clr_mask) | cond_high;
  assign nxt_trip_low  = (trip_low_ff & ~clr_mask) | cond_low;
  assign overview      = trip_high_ff | trip_low_ff;

  // Read data is captured before the clear, so the host sees what tripped.
  always_comb begin
    nxt_rdata = UNMAPPED_RD;
    unique case (reg_req.addr)
      OVERVIEW_ADDR:   nxt_rdata = EIGHT_CH ? overview : {ABSENT_NIBBLE, overview[3:0]};
      TRIP_LOW4_ADDR:  nxt_rdata = pack_flags(trip_low_ff[3:0], trip_high_ff[3:0]);
      ACT_LOW4_ADDR:   nxt_rdata = pack_flags(act_low_ff[3:0], act_high_ff[3:0]);
      TRIP_HIGH4_ADDR: nxt_rdata = EIGHT_CH ? pack_flags(trip_low_ff[7:4], trip_high_ff[7:4])
                                            : ABSENT_RD;
      ACT_HIGH4_ADDR:  nxt_rdata = EIGHT_CH ? pack_flags(act_low_ff[7:4], act_high_ff[7:4])
                                            : ABSENT_RD;
      default:         nxt_rdata = UNMAPPED_RD;
    endcase
  end

  // Active flags are re-evaluated on every conversion of their channel.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_high_ff <= FLAG_RESET;
      act_low_ff  <= FLAG_RESET;
    end else begin
      act_high_ff <= (act_high_ff & ~conv_hit) | cond_high;
      act_low_ff  <= (act_low_ff & ~conv_hit) | cond_low;
    end
  end

  // Tripped flags, one means an alarm was seen.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trip_high_ff <= FLAG_RESET;
      trip_low_ff  <= FLAG_RESET;
      alarm_ff     <= 1'b0;
    end else begin
      trip_high_ff <= nxt_trip_high;
      trip_low_ff  <= nxt_trip_low;
      alarm_ff     <= |{nxt_trip_high, nxt_trip_low};
    end
  end

  // Read answer registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff          <= UNMAPPED_RD;
      rvalid_ff         <= 1'b0;
      span_rd_ff        <= 1'b0;
      span_absent_rd_ff <= 1'b0;
    end else begin
      rdata_ff          <= nxt_rdata;
      rvalid_ff         <= reg_req.rd_en;
      span_rd_ff        <= span_live;
      span_absent_rd_ff <= span_hit && !span_live;
    end
  end

  // Final byte selects between flop outputs only; the mem answer is itself a register.
  assign serial_data_output = span_absent_rd_ff ? ABSENT_RD :
                              span_rd_ff ? {SPAN_UPPER_RD, span_host_q} : rdata_ff;
  assign reg_rvalid          = rvalid_ff;
  assign alarm_out           = alarm_ff;
  assign channel_span_select = span_query_q;
  assign span_code_legal     = span_query_q inside {SPAN_BI_2P5, SPAN_BI_1P25, SPAN_BI_0P625,
                                                    SPAN_UNI_2P5, SPAN_UNI_1P25};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_span_upper_zero: assert property (rvalid_ff && span_rd_ff |->
    serial_data_output[7:4] == SPAN_UPPER_RD) else $error("Span upper nibble not zero.");

  a_span_store: assert property (reg_req.wr_en && span_live ##1
    reg_req.rd_en && reg_req.addr == $past(reg_req.addr) |=>
    serial_data_output[3:0] == $past(reg_req.wdata[3:0], 2)) else $error("Span not stored.");

  a_high_trips: assert property (cond_high[conv.ch] |=>
    trip_high_ff[$past(conv.ch)] && act_high_ff[$past(conv.ch)] && alarm_out)
    else $error("High crossing did not set flags.");

  a_active_drops: assert property (conv.valid && !cond_low[conv.ch] |=>
    !act_low_ff[$past(conv.ch)]) else $error("Active low flag stuck.");

  a_trip_holds: assert property (trip_low_ff[0] && !rd_trip_lo4 |=> trip_low_ff[0])
    else $error("Tripped flag lost without read.");

  a_set_wins: assert property (rd_trip_lo4 && cond_low[conv.ch] |=>
    trip_low_ff[$past(conv.ch)]) else $error("Event lost in clear cycle.");

  a_overview_or: assert property (reg_req.rd_en && reg_req.addr == OVERVIEW_ADDR && EIGHT_CH
    |=> serial_data_output == $past(trip_high_ff | trip_low_ff))
    else $error("Overview not OR of flags.");

  a_absent_ones: assert property (reg_req.rd_en && !EIGHT_CH &&
    reg_req.addr == TRIP_HIGH4_ADDR |=> serial_data_output == ABSENT_RD && reg_rvalid)
    else $error("Absent register not all ones.");

  a_absent_write: assert property (reg_req.wr_en && span_hit && !ch_present(span_ch)
    |=> $stable(u_span_mem.mem_ff)) else $error("Absent span written.");

  // Alarm flags on conversions: both thresholds, set and drop, quiet between results.
  a_low_trips: assert property (
    cond_low[conv.ch]
    |=> trip_low_ff[$past(conv.ch)] && act_low_ff[$past(conv.ch)] && alarm_out)
    else $error("Low crossing did not set flags.");

  a_high_drops: assert property (
    conv.valid && !cond_high[conv.ch]
    |=> !act_high_ff[$past(conv.ch)])
    else $error("Active high flag stuck.");

  a_active_holds: assert property (
    !conv.valid
    |=> act_high_ff == $past(act_high_ff) && act_low_ff == $past(act_low_ff))
    else $error("Active flag moved without a conversion.");

  a_trip_no_event: assert property (
    !conv.valid
    |=> !(|(trip_high_ff & ~$past(trip_high_ff))) &&
        !(|(trip_low_ff & ~$past(trip_low_ff))))
    else $error("Tripped flag set without a crossing.");

  // A read clears only the four channels its register holds; the overview clears nothing.
  a_clear_low4: assert property (
    rd_trip_lo4 && !(|cond_low[3:0]) && !(|cond_high[3:0])
    |=> trip_low_ff[3:0] == 4'h0 && trip_high_ff[3:0] == 4'h0)
    else $error("Read of lower tripped byte did not clear.");

  a_clear_high4: assert property (
    rd_trip_hi4 && !(|cond_low[7:4]) && !(|cond_high[7:4])
    |=> trip_low_ff[7:4] == 4'h0 && trip_high_ff[7:4] == 4'h0)
    else $error("Read of upper tripped byte did not clear.");

  a_overview_keeps: assert property (
    reg_req.rd_en && reg_req.addr == OVERVIEW_ADDR
    |=> !(|($past(trip_high_ff) & ~trip_high_ff)) &&
        !(|($past(trip_low_ff) & ~trip_low_ff)))
    else $error("Overview read cleared a flag.");

  // The pin follows the tripped flags, so a host that polls nothing still hears of every event.
  a_alarm_pin: assert property (
    alarm_out == (|{trip_high_ff, trip_low_ff}))
    else $error("Alarm pin disagrees with tripped flags.");

  // Flag byte layout: low flag above high flag, channel 0 or 4 in the top pair.
  a_map_trip_low4: assert property (
    reg_req.rd_en && reg_req.addr == TRIP_LOW4_ADDR
    |=> serial_data_output[7] == $past(trip_low_ff[0]) &&
        serial_data_output[6] == $past(trip_high_ff[0]) &&
        serial_data_output[0] == $past(trip_high_ff[3]))
    else $error("Lower tripped byte out of order.");

  a_map_act_low4: assert property (
    reg_req.rd_en && reg_req.addr == ACT_LOW4_ADDR
    |=> serial_data_output[5] == $past(act_low_ff[1]) &&
        serial_data_output[2] == $past(act_high_ff[2]))
    else $error("Lower active byte out of order.");

  a_map_trip_high4: assert property (
    reg_req.rd_en && reg_req.addr == TRIP_HIGH4_ADDR && EIGHT_CH
    |=> serial_data_output[5] == $past(trip_low_ff[5]) &&
        serial_data_output[1] == $past(trip_low_ff[7]))
    else $error("Upper tripped byte out of order.");

  a_map_act_high4: assert property (
    reg_req.rd_en && reg_req.addr == ACT_HIGH4_ADDR && EIGHT_CH
    |=> serial_data_output[7] == $past(act_low_ff[4]) &&
        serial_data_output[4] == $past(act_high_ff[5]))
    else $error("Upper active byte out of order.");

  a_overview_low4: assert property (
    reg_req.rd_en && reg_req.addr == OVERVIEW_ADDR
    |=> serial_data_output[3:0] == $past(trip_high_ff[3:0] | trip_low_ff[3:0]))
    else $error("Overview lower nibble not OR of flags.");

  // Four-channel build: absent channels never alarm and read back as ones.
  a_absent_quiet: assert property (
    !EIGHT_CH
    |-> !(|{act_high_ff[7:4], act_low_ff[7:4], trip_high_ff[7:4], trip_low_ff[7:4]}))
    else $error("Absent channel raised a flag.");

  a_absent_span: assert property (
    reg_req.rd_en && span_hit && !span_live
    |=> serial_data_output == ABSENT_RD)
    else $error("Absent span register not all ones.");

  a_absent_active: assert property (
    reg_req.rd_en && !EIGHT_CH && reg_req.addr == ACT_HIGH4_ADDR
    |=> serial_data_output == ABSENT_RD)
    else $error("Absent active byte not all ones.");

  a_overview_ones: assert property (
    reg_req.rd_en && !EIGHT_CH && reg_req.addr == OVERVIEW_ADDR
    |=> serial_data_output[7:4] == ABSENT_NIBBLE)
    else $error("Absent overview bits not ones.");

  // Read handshake: one answer pulse per read strobe, zeros between the register groups.
  a_answer_pulse: assert property (
    reg_req.rd_en
    |=> reg_rvalid)
    else $error("Read not answered.");

  a_answer_quiet: assert property (
    !reg_req.rd_en
    |=> !reg_rvalid)
    else $error("Answer without a read.");

  a_gap_reads_zero: assert property (
    reg_req.rd_en && reg_req.addr > SPAN_LAST_ADDR && reg_req.addr < OVERVIEW_ADDR
    |=> serial_data_output == UNMAPPED_RD)
    else $error("Unmapped address not zero.");

  // Every legal span code keeps its top bit clear, a check independent of the decode list.
  a_span_legal_msb: assert property (
    span_code_legal
    |-> !channel_span_select[SPAN_W-1])
    else $error("Legal span code with top bit set.");

endmodule

// ---- tb/araf_host_model.sv ----
// Purpose: Host controller model that issues byte reads and writes to the register bank.
// Assumes: Every access launches at a falling edge of clk_sys and is taken at the next rise.
// Notes:   An idle request shows the inverted address so a stale address never looks live.
module araf_host_model
  import araf_pkg::*;
(
  input  wire logic              clk_sys,
  output araf_reg_req_type       reg_req,
  input  wire logic              reg_rvalid,
  input  wire logic [DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial reg_req = '0;

  // One write strobe, held for exactly the cycle in which it is taken.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_sys);
    reg_req = '{addr: a, wr_en: 1'b1, rd_en: 1'b0, wdata: d};
    @(negedge clk_sys);
    reg_req = '{addr: ~a, wr_en: 1'b0, rd_en: 1'b0, wdata: ~d};
  endtask

  // The answer stands for one cycle after the taking edge, so it is sampled mid-cycle.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
    @(negedge clk_sys);
    reg_req = '{addr: a, wr_en: 1'b0, rd_en: 1'b1, wdata: 8'h00};
    @(negedge clk_sys);
    reg_req = '{addr: ~a, wr_en: 1'b0, rd_en: 1'b0, wdata: 8'hff};
    d = rdata;
    v = reg_rvalid;
  endtask

  // Write, then read the same address in the very next cycle.
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                       output logic [DATA_W-1:0] d, output logic v);
    @(negedge clk_sys);
    reg_req = '{addr: a, wr_en: 1'b1, rd_en: 1'b0, wdata: wd};
    @(negedge clk_sys);
    reg_req = '{addr: a, wr_en: 1'b0, rd_en: 1'b1, wdata: 8'h00};
    @(negedge clk_sys);
    reg_req = '{addr: ~a, wr_en: 1'b0, rd_en: 1'b0, wdata: 8'hff};
    d = rdata;
    v = reg_rvalid;
  endtask
endmodule

// ---- tb/araf_top_tb.sv ----
// Purpose: Self-checking bench for the span select and alarm flag register bank.
// Assumes: Eight-channel and four-channel builds share every input.
// Notes:   The four-channel build is checked on every rd_chk read through its own expectation.
module araf_top_tb
  import araf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                          clk_sys       = 1'b0;
  logic                          rst           = 1'b1;
  araf_reg_req_type              reg_req;
  araf_conv_type                 conv          = '0;
  logic [NUM_CH-1:0][CONV_W-1:0] thr_high      = {NUM_CH{18'h003e8}};
  logic [NUM_CH-1:0][CONV_W-1:0] thr_low       = {NUM_CH{18'h00064}};
  logic [CH_W-1:0]               span_query_ch = '0;
  logic                          rvalid;
  logic                          span_legal;
  logic                          alarm;
  logic                          alarm4;
  logic                          rvalid4;
  logic [SPAN_W-1:0]             span_sel4;
  logic [DATA_W-1:0]             rdata;
  logic [DATA_W-1:0]             rdata4;
  logic [SPAN_W-1:0]             span_sel;
  logic [SPAN_W-1:0]             codes [5]     = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
  int                            errors        = 0;
  int                            checked       = 0;

  always #2 clk_sys = ~clk_sys;

  araf_top #(.EIGHT_CH(1'b1)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rvalid(rvalid),
    .serial_data_output(rdata), .conv(conv), .thr_high(thr_high), .thr_low(thr_low),
    .span_query_ch(span_query_ch), .channel_span_select(span_sel),
    .span_code_legal(span_legal), .alarm_out(alarm));

  araf_top #(.EIGHT_CH(1'b0)) i_dut4 (
    .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rvalid(rvalid4),
    .serial_data_output(rdata4), .conv(conv), .thr_high(thr_high), .thr_low(thr_low),
    .span_query_ch(span_query_ch), .channel_span_select(span_sel4), .span_code_legal(),
    .alarm_out(alarm4));

  araf_host_model i_host (
    .clk_sys(clk_sys), .reg_req(reg_req), .reg_rvalid(rvalid), .rdata(rdata));

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Absent upper channels of the four-channel build read as ones.
  function automatic logic [DATA_W-1:0] exp4(input logic [ADDR_W-1:0] a,
                                             input logic [DATA_W-1:0] e);
    if ((a >= 7'h09 && a <= 7'h0c) || a >= 7'h13) return 8'hff;
    if (a == 7'h10) return {4'hf, e[3:0]};
    return e;
  endfunction

  // Both builds answer the same read; the valid pulses of both builds are watched.
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    logic              v;
    i_host.rd(a, d, v);
    check({7'h00, v}, 8'h01);
    check({7'h00, rvalid4}, 8'h01);
    check(d, e);
    check(rdata4, exp4(a, e));
  endtask

  // A conversion result is presented for exactly one cycle.
  task automatic cv(input logic [CH_W-1:0] ch, input logic [CONV_W-1:0] d);
    @(negedge clk_sys);
    conv = '{valid: 1'b1, ch: ch, data: d};
    @(negedge clk_sys);
    conv.valid = 1'b0;
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial begin
    #50000;
    errors++;
    final_report();
  end

  initial begin
    logic [DATA_W-1:0] d;
    logic              v;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    for (int a = 5; a <= 20; a++) rd_chk(7'(a), 8'h00);
    // The host keeps the read-only upper nibble at zero, as it must.
    for (int c = 0; c < 8; c++) i_host.wr(7'(5 + c), {4'h0, codes[c % 5]});
    for (int c = 0; c < 8; c++) begin
      rd_chk(7'(5 + c), {4'h0, codes[c % 5]});
      span_query_ch = 3'(c);
      @(negedge clk_sys);
      check({4'h0, span_sel}, {4'h0, codes[c % 5]});
      check({7'h00, span_legal}, 8'h01);
      check({4'h0, span_sel4}, {4'h0, (c < 4) ? codes[c % 5] : SPAN_RESET});
    end
    // Write then read in consecutive cycles returns the new value.
    i_host.wr_rd(7'h05, 8'h06, d, v);
    check({7'h00, v}, 8'h01);
    check(d, 8'h06);
    check(rdata4, 8'h06);
    i_host.wr(7'h0c, 8'h03);
    @(negedge clk_sys);
    check({7'h00, span_legal}, 8'h00);
    rd_chk(7'h0c, 8'h03);
    // A value equal to the threshold is not a crossing.
    cv(3'd2, 18'h003e8);
    rd_chk(7'h11, 8'h00);
    cv(3'd2, 18'h003e9);
    check({7'h00, alarm}, 8'h01);
    rd_chk(7'h12, 8'h04);
    cv(3'd2, 18'h001f4);
    rd_chk(7'h12, 8'h00);
    rd_chk(7'h10, 8'h04);
    rd_chk(7'h10, 8'h04);
    rd_chk(7'h11, 8'h04);
    rd_chk(7'h11, 8'h00);
    check({7'h00, alarm}, 8'h00);
    cv(3'd5, 18'h00063);
    check({7'h00, alarm}, 8'h01);
    check({7'h00, alarm4}, 8'h00);
    rd_chk(7'h14, 8'h20);
    rd_chk(7'h10, 8'h20);
    rd_chk(7'h13, 8'h20);
    rd_chk(7'h13, 8'h00);
    // A read that clears in the same cycle as a new crossing must not lose it.
    fork
      i_host.rd(7'h11, d, v);
      cv(3'd0, 18'h00000);
    join
    check(d, 8'h00);
    rd_chk(7'h11, 8'h80);
    final_report();
  end
endmodule
